//--- pkg/acq_seq_defines.vh
`ifndef ACQ_SEQ_DEFINES_VH
`define ACQ_SEQ_DEFINES_VH
// ----------------------------------------
// phase encodings (one-hot)
// ----------------------------------------
`define ST_IDLE    6'h01
`define ST_DELAY   6'h02
`define ST_PRE     6'h04
`define ST_ARMED   6'h08
`define ST_POST    6'h10
`define ST_DONE    6'h20
// ----------------------------------------
// timing
// ----------------------------------------
`define START_DELAY_TICKS 16'h0002
`define ONE_CNT           32'h0000_0001
`define ZERO_CNT          32'h0000_0000
`define ONE_TICK          16'h0001
`define ZERO_TICK         16'h0000
`endif

//--- design/ai_trigger_sample_sequencer.v
// Contract
// - one sample pulse converts every channel together
// - posttrigger count loaded, decremented per sample
// - start loads pretrigger count, then decrements
// - reload posttrigger count after pretrigger phase
// - early pivot trigger ignored, keep waiting
// - accepted pivot: decrement until posttrigger done
// - start from hardware or software, configurable
// - software start echoed as output pulse
// - pause only on non high-speed variants
// - aggregate rate is per-channel times channels
// - sample pulses ignored while not acquiring
// - start to first sample delay, default two
`timescale 1ns/100ps
`default_nettype none
`include "acq_seq_defines.vh"
module ai_trigger_sample_sequencer #(
  parameter NCH      = 8,
  parameter DW       = 16,
  parameter CW       = 32,
  parameter HIGH_SPEED = 0
) (
  input  wire              clk,
  input  wire              nrst,
  input  wire              cfg_arm,
  input  wire              cfg_pretrig_en,
  input  wire              cfg_sw_start_sel,
  input  wire              cfg_pause_en,
  input  wire [CW-1:0]     cfg_pre_count,
  input  wire [CW-1:0]     cfg_post_count,
  input  wire [15:0]       cfg_start_delay,
  input  wire              sw_start,
  input  wire              acq_begin_trigger,
  input  wire              acq_pivot_trigger,
  input  wire              acq_pause,
  input  wire              acq_sample_timebase,
  input  wire [NCH*DW-1:0] adc_data,
  input  wire              out_ready,
  output reg               conv_start,
  output reg               begin_echo,
  output reg  [NCH*DW-1:0] out_data,
  output reg               out_valid,
  output reg               busy,
  output reg               done,
  output reg  [CW-1:0]     sample_count,
  output reg               adc_take
);
  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  reg [2:0] hw_sync_reg;
  reg [2:0] piv_sync_reg;
  reg [2:0] pau_sync_reg;
  reg [2:0] tb_sync_reg;
  always @(posedge clk) begin
    if (!nrst) begin
      hw_sync_reg  <= 3'h0;
      piv_sync_reg <= 3'h0;
      pau_sync_reg <= 3'h0;
      tb_sync_reg  <= 3'h0;
    end else begin
      hw_sync_reg  <= {hw_sync_reg[1:0], acq_begin_trigger};
      piv_sync_reg <= {piv_sync_reg[1:0], acq_pivot_trigger};
      pau_sync_reg <= {pau_sync_reg[1:0], acq_pause};
      tb_sync_reg  <= {tb_sync_reg[1:0], acq_sample_timebase};
    end
  end
  // a change counts once stages 2 and 3 agree
  reg hw_lvl_reg;
  reg piv_lvl_reg;
  reg pau_lvl_reg;
  reg tb_lvl_reg;
  wire hw_nxt  = (hw_sync_reg[2] == hw_sync_reg[1]) ? hw_sync_reg[2] : hw_lvl_reg;
  wire piv_nxt = (piv_sync_reg[2] == piv_sync_reg[1]) ? piv_sync_reg[2] : piv_lvl_reg;
  wire pau_nxt = (pau_sync_reg[2] == pau_sync_reg[1]) ? pau_sync_reg[2] : pau_lvl_reg;
  wire tb_nxt  = (tb_sync_reg[2] == tb_sync_reg[1]) ? tb_sync_reg[2] : tb_lvl_reg;
  always @(posedge clk) begin
    if (!nrst) begin
      hw_lvl_reg  <= 1'b0;
      piv_lvl_reg <= 1'b0;
      pau_lvl_reg <= 1'b0;
      tb_lvl_reg  <= 1'b0;
    end else begin
      hw_lvl_reg  <= hw_nxt;
      piv_lvl_reg <= piv_nxt;
      pau_lvl_reg <= pau_nxt;
      tb_lvl_reg  <= tb_nxt;
    end
  end
  wire hw_rise  = hw_nxt & ~hw_lvl_reg;
  wire piv_rise = piv_nxt & ~piv_lvl_reg;
  wire tb_rise  = tb_nxt & ~tb_lvl_reg;
  wire paused   = pau_lvl_reg & cfg_pause_en & (HIGH_SPEED == 0);

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  reg [5:0]    state_reg;
  reg [5:0]    state_next;
  reg [CW-1:0] cnt_next;
  reg [15:0]   dly_reg;
  reg [15:0]   dly_next;
  reg          pre_full_reg;
  reg          pre_full_next;
  wire         start_ev = cfg_sw_start_sel ? sw_start : hw_rise;
  wire         buf_in_ready;
  // internal engine: one sample tick per timebase rising edge, when not paused and the buffer has room
  wire         sample_ev = tb_rise & ~paused & buf_in_ready;
  wire [15:0]  dly_load = (cfg_start_delay == `ZERO_TICK) ? `START_DELAY_TICKS
                                                         : cfg_start_delay;
  reg          take;
  always @* begin
    state_next    = state_reg;
    cnt_next      = sample_count;
    dly_next      = dly_reg;
    pre_full_next = pre_full_reg;
    take          = 1'b0;
    case (state_reg)
      `ST_IDLE: begin
        if (cfg_arm && start_ev) begin
          state_next = `ST_DELAY;
          dly_next   = dly_load;
          pre_full_next = 1'b0;
          if (cfg_pretrig_en)
            cnt_next = cfg_pre_count;
          else
            cnt_next = cfg_post_count;
        end
      end
      `ST_DELAY: begin
        if (tb_rise) begin
          if (dly_reg <= `ONE_TICK)
            state_next = cfg_pretrig_en ? `ST_PRE : `ST_POST;
          else
            dly_next = dly_reg - `ONE_TICK;
        end
      end
      `ST_PRE: begin
        if (sample_ev) begin
          take = 1'b1;
          if (sample_count <= `ONE_CNT) begin
            pre_full_next = 1'b1;
            cnt_next   = cfg_post_count;
            state_next = `ST_ARMED;
          end else
            cnt_next = sample_count - `ONE_CNT;
        end
      end
      `ST_ARMED: begin
        // ring keeps sampling; a pivot before here is never seen
        if (sample_ev)
          take = 1'b1;
        if (piv_rise && pre_full_reg)
          state_next = `ST_POST;
      end
      `ST_POST: begin
        if (sample_count == `ZERO_CNT)
          state_next = `ST_DONE;
        else if (sample_ev) begin
          take = 1'b1;
          cnt_next = sample_count - `ONE_CNT;
          if (sample_count == `ONE_CNT)
            state_next = `ST_DONE;
        end
      end
      `ST_DONE: begin
        state_next = `ST_IDLE;
      end
      default: begin
        state_next = `ST_IDLE;
      end
    endcase
  end
  always @(posedge clk) begin
    if (!nrst) begin
      state_reg    <= `ST_IDLE;
      sample_count <= `ZERO_CNT;
      dly_reg      <= `ZERO_TICK;
      pre_full_reg <= 1'b0;
      conv_start   <= 1'b0;
      adc_take     <= 1'b0;
      begin_echo   <= 1'b0;
      busy         <= 1'b0;
      done         <= 1'b0;
    end else begin
      state_reg    <= state_next;
      sample_count <= cnt_next;
      dly_reg      <= dly_next;
      pre_full_reg <= pre_full_next;
      conv_start   <= take;
      adc_take     <= take;
      begin_echo   <= (state_reg == `ST_IDLE) && (state_next == `ST_DELAY)
                      && cfg_sw_start_sel;
      busy         <= (state_next != `ST_IDLE) && (state_next != `ST_DONE);
      done         <= (state_next == `ST_DONE);
    end
  end

  // ----------------------------------------
  // two-entry output buffer
  // ----------------------------------------
  // adc_data is captured while adc_take is high, the same cycle as conv_start; every channel is
  // captured as one word so all conversions share one instant
  reg [NCH*DW-1:0] skid_reg;
  reg              skid_vld_reg;
  assign buf_in_ready = ~skid_vld_reg;
  always @(posedge clk) begin
    if (!nrst) begin
      out_valid    <= 1'b0;
      out_data     <= {NCH*DW{1'b0}};
      skid_vld_reg <= 1'b0;
      skid_reg     <= {NCH*DW{1'b0}};
    end else begin
      if (!out_valid || out_ready) begin
        if (skid_vld_reg) begin
          out_data     <= skid_reg;
          out_valid    <= 1'b1;
          skid_vld_reg <= adc_take;
          skid_reg     <= adc_data;
        end else begin
          out_valid <= adc_take;
          if (adc_take)
            out_data <= adc_data;
        end
      end else if (adc_take) begin
        skid_vld_reg <= 1'b1;
        skid_reg     <= adc_data;
      end
    end
  end
endmodule
`default_nettype wire

//--- verif/adc_front.sv
`timescale 1ns/100ps
`default_nettype none
module adc_front #(parameter int W = 128, parameter int HALF = 4) (
  input  wire logic         clk,
  output wire logic         tick,
  output wire logic [W-1:0] data
);
  logic         t = 1'b0;
  logic [W-1:0] d = '0;
  int           n = 0;
  assign tick = t;
  assign data = d;
  // slow timebase keeps the per-channel and aggregate rates low
  always @(posedge clk) begin
    n <= (n == HALF - 1) ? 0 : n + 1;
    if (n == HALF - 1) t <= ~t;
    d <= {W/32{$urandom}};
  end
endmodule
`default_nettype wire

//--- verif/acq_seq_chk_sva.sv
`timescale 1ns/100ps
`default_nettype none
module acq_seq_chk #(
  parameter NCH = 8,
  parameter DW  = 16,
  parameter CW  = 32
) (
  input wire logic              clk,
  input wire logic              nrst,
  input wire logic              cfg_sw_start_sel,
  input wire logic              out_ready,
  input wire logic              conv_start,
  input wire logic              adc_take,
  input wire logic              begin_echo,
  input wire logic              out_valid,
  input wire logic              busy,
  input wire logic              done,
  input wire logic [NCH*DW-1:0] out_data
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_take; adc_take |=> out_valid; endproperty
  a_take: assert property (p_take) else $error("taken sample not offered");
  property p_idle; !busy && !$past(busy) |-> !conv_start; endproperty
  a_idle: assert property (p_idle) else $error("sample while idle");
  property p_echo; begin_echo |-> busy && cfg_sw_start_sel; endproperty
  a_echo: assert property (p_echo) else $error("bad start echo");
  property p_echo1; begin_echo |=> !begin_echo; endproperty
  a_echo1: assert property (p_echo1) else $error("echo too long");
  property p_delay; $rose(busy) |-> !conv_start [*4]; endproperty
  a_delay: assert property (p_delay) else $error("no start delay");
  property p_done1; done |=> !done; endproperty
  a_done1: assert property (p_done1) else $error("done too long");
  property p_done2; done |-> !busy; endproperty
  a_done2: assert property (p_done2) else $error("busy at done");
  property p_hold; out_valid && !out_ready |=> out_valid && $stable(out_data); endproperty
  a_hold: assert property (p_hold) else $error("word lost in stall");
  c_done: cover property (done);
  c_echo: cover property (begin_echo);
  c_stall: cover property (out_valid && !out_ready);
endmodule
bind ai_trigger_sample_sequencer acq_seq_chk #(.NCH(NCH), .DW(DW), .CW(CW)) u_chk (
  .clk, .nrst, .cfg_sw_start_sel, .out_ready, .conv_start, .adc_take, .begin_echo,
  .out_valid, .busy, .done, .out_data);
`default_nettype wire

//--- verif/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam int W = 128;
  logic clk = 0, nrst = 0, arm = 0, pe = 0, ss = 0, sws = 0, hw = 0, piv = 0, rdy = 0;
  logic [31:0] pc = 0, qc = 0;
  logic [15:0] dly = 0;
  wire logic tb_t, cs, echo, ov, bsy, dn, take;
  wire logic [W-1:0] adc, od;
  wire logic [31:0] cnt;
  logic [W-1:0] q[$];
  int n_mismatch = 0, compares = 0, nsamp = 0, n_echo = 0, got_done = 0, n_conv = 0;
  always #2 clk = ~clk;
  adc_front #(.W(W)) far (.clk(clk), .tick(tb_t), .data(adc));
  ai_trigger_sample_sequencer dut (.clk(clk), .nrst(nrst), .cfg_arm(arm), .cfg_pretrig_en(pe),
    .cfg_sw_start_sel(ss), .cfg_pause_en(1'b0), .cfg_pre_count(pc), .cfg_post_count(qc),
    .cfg_start_delay(dly), .sw_start(sws), .acq_begin_trigger(hw), .acq_pivot_trigger(piv),
    .acq_pause(1'b0), .acq_sample_timebase(tb_t), .adc_data(adc), .out_ready(rdy),
    .conv_start(cs), .begin_echo(echo), .out_data(od), .out_valid(ov), .busy(bsy),
    .done(dn), .sample_count(cnt), .adc_take(take));
  task automatic chk(input logic e, g);
    compares++;
    if (e !== g) begin
      n_mismatch++;
      $display("[ERR] %0t flag mismatch", $time);
    end
  endtask
  task automatic chk_d(input logic [W-1:0] e, g);
    compares++;
    if (e !== g) begin
      n_mismatch++;
      $display("[ERR] %0t data mismatch", $time);
    end
  endtask
  task automatic chk_n(input logic [31:0] e, g);
    compares++;
    if (e !== g) begin
      n_mismatch++;
      $display("[ERR] %0t count mismatch", $time);
    end
  endtask
  task automatic test_done;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // consumer stalls at random
  always @(posedge clk) rdy <= 1'($urandom);
  always @(posedge clk) begin
    if (take) q.push_back(adc);
    if (echo) n_echo++;
    if (cs) n_conv++;
    if (dn) got_done = 1;
    if (ov && rdy) begin
      nsamp++;
      if (q.size() == 0) chk(1'b0, 1'b1);
      else chk_d(q.pop_front(), od);
    end
  end
  task automatic run(input logic p, s, input int a, b, input logic [15:0] d);
    int e0, c0, k;
    @(posedge clk);
    pe <= p; ss <= s; pc <= a; qc <= b; dly <= d; arm <= 1'b1;
    nsamp = 0; e0 = n_echo; got_done = 0;
    c0 = n_conv;
    @(posedge clk);
    if (s) sws <= 1'b1;
    else hw <= 1'b1;
    // early pivot lands before any pretrigger sample
    @(posedge clk); sws <= 1'b0; piv <= p;
    @(posedge clk); hw <= 1'b0;
    repeat (3) @(posedge clk); piv <= 1'b0;
    if (p) begin
      k = 0;
      while (nsamp < a + 2 && k < 3000) begin @(posedge clk); k++; end
      chk(1'b1, bsy);
      chk_n(b, cnt);
      piv <= 1'b1;
      repeat (4) @(posedge clk); piv <= 1'b0;
    end
    k = 0;
    while (!got_done && k < 3000) begin @(posedge clk); k++; end
    repeat (60) @(posedge clk);
    chk(1'b1, got_done != 0);
    chk(s, n_echo != e0);
    if (p) chk(1'b1, nsamp >= a + b);
    else chk(1'b1, nsamp == b);
    chk(1'b1, q.size() == 0);
    chk(1'b0, bsy);
    chk_n(32'h0, cnt);
    chk_n(nsamp, n_conv - c0);
  endtask
  initial begin
    void'($urandom(32'he6ce));
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    for (int i = 0; i < 4; i++) run(i[1], i[0], 2 + $urandom % 3, 1 + $urandom % 4,
      i == 3 ? 16'h0003 : 16'h0000);
    test_done;
  end
  initial begin
    #80000;
    n_mismatch++;
    test_done;
  end
endmodule
`default_nettype wire
